// *** src/bdx_pkg.sv ***
`default_nettype none
package bdx_pkg;
   // register bus layout (byte addresses)
   localparam int unsigned AXI_AW      = 12;
   localparam logic [11:0] A_CTRL      = 12'h000;
   localparam logic [11:0] A_FLAGS     = 12'h004;
   localparam logic [11:0] A_PC        = 12'h008;
   localparam logic [11:0] A_STATUS    = 12'h00c;
   localparam logic [11:0] A_COUNT     = 12'h010;
   localparam logic [11:0] A_GPR_BASE  = 12'h080;
   localparam logic [11:0] A_GPR_MASK  = 12'hf80;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   // control and status field positions
   localparam int unsigned CTRL_RUN    = 0;
   localparam int unsigned STS_BUSY    = 0;
   localparam int unsigned STS_TAKEN   = 1;
   localparam int unsigned STS_BADOP   = 2;
   // flag register bit positions
   localparam logic [2:0]  F_C = 3'h0;
   localparam logic [2:0]  F_Z = 3'h1;
   localparam logic [2:0]  F_N = 3'h2;
   localparam logic [2:0]  F_V = 3'h3;
   localparam logic [2:0]  F_S = 3'h4;
   localparam logic [2:0]  F_H = 3'h5;
   localparam logic [2:0]  F_T = 3'h6;
   localparam logic [2:0]  F_I = 3'h7;
   // pointer pair low-byte register indices
   localparam logic [4:0]  IDX_XL = 5'h1a;
   localparam logic [4:0]  IDX_YL = 5'h1c;
   localparam logic [4:0]  IDX_ZL = 5'h1e;
   // reset values
   localparam logic [15:0] RST_PC    = 16'h0000;
   localparam logic [7:0]  RST_FLAGS = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_MEM   = 3'b010,
      ST_FLUSH = 3'b100
   } bdx_state_e;

   typedef struct packed {
      logic [15:0] word;
      logic [15:0] ext;
   } bdx_instr_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        we;
      logic        re;
   } bdx_dmem_req_s;

   typedef struct packed {
      bdx_state_e      st;
      logic [15:0]     pc;
      logic [7:0]      flags;
      logic [31:0][7:0] gpr;
      logic [4:0]      ld_dst;
      bdx_dmem_req_s   dmem;
      logic            flush;
      logic            ready;
      logic            taken;
      logic            badop;
      logic [31:0]     count;
      logic            run;
      logic            awready;
      logic            wready;
      logic            aw_hold;
      logic [11:0]     aw_addr;
      logic            w_hold;
      logic [31:0]     w_data;
      logic [3:0]      w_strb;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            arready;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
   } bdx_state_s;
endpackage : bdx_pkg
`default_nettype wire

// *** src/bdx_exec.sv ***
// Notes on behaviour
// - branch on a chosen flag bit being clear jumps pc+k+1; 1 cycle untaken, 2 taken.
// - equal/unequal branches follow Z being one/zero; target pc+k+1; flags untouched.
// - carry-high and unsigned-below branch on C one; carry-low and at-least on C zero.
// - negative branch on N one, positive branch on N zero; relative jump k+1.
// - signed branches use N xor V: at-least when zero, below when one.
// - half-carry branches follow H set or clear, jumping relative by k+1.
// - transfer-bit branches follow T one or zero.
// - overflow branches follow V one or zero.
// - irq-state branches follow the global interrupt enable I being one or zero.
// - register copy and immediate load take 1 cycle, write only destination, no flags.
// - pointer read via X, Y or Z in 2 cycles; post-increment bumps pointer after.
// - pre-decrement read lowers the pointer first, then reads the new address.
// - offset read at Y or Z plus q in 2 cycles, pointer unchanged.
// - absolute read loads the byte at address k in 2 cycles.
// - pointer write stores the source at X, Y or Z; post-increment bumps pointer.
// - pre-decrement write lowers the pointer first, then stores there.
// - offset write stores at Y or Z plus q, pointer unchanged.
// - absolute write stores the source at address k in 2 cycles, no flags.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`default_nettype none
module bdx_exec (
   input  wire logic                   sys_clk_i,
   input  wire logic                   nrst_i,
   input  wire logic                   instr_valid_i,
   input  wire bdx_pkg::bdx_instr_s    instr_i,
   output logic                        instr_ready_o,
   output logic [15:0]                 pc_o,
   output logic                        flush_o,
   output logic [7:0]                  flags_o,
   output bdx_pkg::bdx_dmem_req_s      dmem_req_o,
   input  wire logic [7:0]             dmem_rdata_i,
   input  wire logic [11:0]            s_axi_awaddr_i,
   input  wire logic                   s_axi_awvalid_i,
   output logic                        s_axi_awready_o,
   input  wire logic [31:0]            s_axi_wdata_i,
   input  wire logic [3:0]             s_axi_wstrb_i,
   input  wire logic                   s_axi_wvalid_i,
   output logic                        s_axi_wready_o,
   output logic [1:0]                  s_axi_bresp_o,
   output logic                        s_axi_bvalid_o,
   input  wire logic                   s_axi_bready_i,
   input  wire logic [11:0]            s_axi_araddr_i,
   input  wire logic                   s_axi_arvalid_i,
   output logic                        s_axi_arready_o,
   output logic [31:0]                 s_axi_rdata_o,
   output logic [1:0]                  s_axi_rresp_o,
   output logic                        s_axi_rvalid_o,
   input  wire logic                   s_axi_rready_i
);
   import bdx_pkg::*;

   bdx_state_s  s_r;
   bdx_state_s  s_nxt;

   logic [15:0] w;
   logic        acc;
   logic        is_br;
   logic        br_bit;
   logic        br_cond;
   logic [15:0] br_tgt;
   logic        is_mov;
   logic        is_ldi;
   logic        is_abs;
   logic        is_ptr;
   logic        is_disp;
   logic        is_mem;
   logic        store;
   logic [4:0]  d_idx;
   logic [4:0]  r_idx;
   logic [5:0]  ptr_dec;
   logic [4:0]  m_lo;
   logic [15:0] m_ptr;
   logic [15:0] m_new;
   logic [15:0] m_addr;
   logic        inc;
   logic        dec;
   logic [15:0] pc1;
   logic [15:0] pc2;
   logic        sw_idle;

   function automatic logic [15:0] ptr_get(input logic [31:0][7:0] g, input logic [4:0] lo);
      ptr_get = {g[lo | 5'h01], g[lo]};
   endfunction : ptr_get

   // {valid, low index} for the pointer-mode field of a pointer access
   function automatic logic [5:0] ptr_sel(input logic [3:0] m);
      unique case (m)
         4'hc, 4'hd, 4'he: ptr_sel = {1'b1, IDX_XL};
         4'h9, 4'ha:       ptr_sel = {1'b1, IDX_YL};
         4'h1, 4'h2:       ptr_sel = {1'b1, IDX_ZL};
         default:          ptr_sel = 6'h00;
      endcase
   endfunction : ptr_sel

   // {resp, data} for a register read
   function automatic logic [33:0] reg_read(input bdx_state_s st, input logic [11:0] a);
      logic [31:0] v;
      logic [1:0]  rsp;
      v   = 32'h0000_0000;
      rsp = RESP_OKAY;
      if (a == A_CTRL) begin
         v[CTRL_RUN] = st.run;
      end else if (a == A_FLAGS) begin
         v[7:0] = st.flags;
      end else if (a == A_PC) begin
         v[15:0] = st.pc;
      end else if (a == A_STATUS) begin
         v[STS_BUSY]  = (st.st != ST_IDLE);
         v[STS_TAKEN] = st.taken;
         v[STS_BADOP] = st.badop;
      end else if (a == A_COUNT) begin
         v = st.count;
      end else if ((a & A_GPR_MASK) == A_GPR_BASE) begin
         v[7:0] = st.gpr[a[6:2]];
      end else begin
         rsp = RESP_SLVERR;
      end
      reg_read = {rsp, v};
   endfunction : reg_read

   assign w       = instr_i.word;
   assign acc     = instr_valid_i && s_r.ready;
   assign pc1     = s_r.pc + 16'h0001;
   assign pc2     = s_r.pc + 16'h0002;
   assign sw_idle = !s_r.run && (s_r.st == ST_IDLE);

   // both branch polarities share one decode: bit 10 selects the clear form
   assign is_br   = (w[15:11] == 5'b11110);
   assign br_bit  = (w[2:0] == F_S) ? (s_r.flags[F_N] ^ s_r.flags[F_V])
                                    : s_r.flags[w[2:0]];
   assign br_cond = br_bit ^ w[10];
   assign br_tgt  = s_r.pc + {{9{w[9]}}, w[9:3]} + 16'h0001;

   assign is_mov  = (w[15:10] == 6'b001011);
   assign is_ldi  = (w[15:12] == 4'b1110);
   assign is_abs  = (w[15:10] == 6'b100100) && (w[3:0] == 4'h0);
   assign ptr_dec = ptr_sel(w[3:0]);
   assign is_ptr  = (w[15:10] == 6'b100100) && ptr_dec[5];
   assign is_disp = (w[15:14] == 2'b10) && !w[12];
   assign is_mem  = is_abs || is_ptr || is_disp;
   assign store   = w[9];
   assign d_idx   = w[8:4];
   assign r_idx   = {w[9], w[3:0]};
   assign inc     = is_ptr && (w[1:0] == 2'b01);
   assign dec     = is_ptr && (w[1:0] == 2'b10);
   assign m_lo    = is_disp ? (w[3] ? IDX_YL : IDX_ZL) : ptr_dec[4:0];
   assign m_ptr   = ptr_get(s_r.gpr, m_lo);
   assign m_new   = dec ? (m_ptr - 16'h0001) : (m_ptr + 16'h0001);

   always_comb begin
      if (is_abs) begin
         m_addr = instr_i.ext;
      end else if (is_disp) begin
         m_addr = m_ptr + {10'h000, w[13], w[11:10], w[2:0]};
      end else if (dec) begin
         m_addr = m_new;
      end else begin
         m_addr = m_ptr;
      end
   end

   always_comb begin
      s_nxt = s_r;
      // register bus: response channels
      if (s_r.bvalid && s_axi_bready_i) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.rvalid && s_axi_rready_i) begin
         s_nxt.rvalid = 1'b0;
      end
      // register bus: commit a write once address and data are both held
      if (s_r.aw_hold && s_r.w_hold && !s_r.bvalid) begin
         s_nxt.aw_hold = 1'b0;
         s_nxt.w_hold  = 1'b0;
         s_nxt.bvalid  = 1'b1;
         s_nxt.bresp   = RESP_OKAY;
         if (s_r.aw_addr == A_CTRL) begin
            if (s_r.w_strb[0]) begin
               s_nxt.run = s_r.w_data[CTRL_RUN];
            end
         end else if (s_r.aw_addr == A_FLAGS) begin
            if (s_r.w_strb[0] && sw_idle) begin
               s_nxt.flags = s_r.w_data[7:0];
            end
         end else if (s_r.aw_addr == A_PC) begin
            if (s_r.w_strb[0] && sw_idle) begin
               s_nxt.pc[7:0] = s_r.w_data[7:0];
            end
            if (s_r.w_strb[1] && sw_idle) begin
               s_nxt.pc[15:8] = s_r.w_data[15:8];
            end
         end else if (s_r.aw_addr == A_STATUS) begin
            if (s_r.w_strb[0] && s_r.w_data[STS_BADOP]) begin
               s_nxt.badop = 1'b0;
            end
         end else if (s_r.aw_addr == A_COUNT) begin
            s_nxt.bresp = RESP_OKAY;
         end else if ((s_r.aw_addr & A_GPR_MASK) == A_GPR_BASE) begin
            if (s_r.w_strb[0] && sw_idle) begin
               s_nxt.gpr[s_r.aw_addr[6:2]] = s_r.w_data[7:0];
            end
         end else begin
            s_nxt.bresp = RESP_SLVERR;
         end
      end
      if (s_r.awready && s_axi_awvalid_i) begin
         s_nxt.aw_hold = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr_i;
      end
      if (s_r.wready && s_axi_wvalid_i) begin
         s_nxt.w_hold = 1'b1;
         s_nxt.w_data = s_axi_wdata_i;
         s_nxt.w_strb = s_axi_wstrb_i;
      end
      if (s_r.arready && s_axi_arvalid_i) begin
         s_nxt.rvalid = 1'b1;
         {s_nxt.rresp, s_nxt.rdata} = reg_read(s_r, s_axi_araddr_i);
      end

      // execution; runs after the bus so a hardware set of badop beats a clear
      s_nxt.flush   = 1'b0;
      s_nxt.dmem.re = 1'b0;
      s_nxt.dmem.we = 1'b0;
      unique case (s_r.st)
         ST_IDLE: begin
            if (acc) begin
               s_nxt.count = s_r.count + 32'h0000_0001;
               s_nxt.pc    = pc1;
               if (is_br) begin
                  s_nxt.taken = br_cond;
                  if (br_cond) begin
                     s_nxt.pc    = br_tgt;
                     s_nxt.flush = 1'b1;
                     s_nxt.st    = ST_FLUSH;
                  end
               end else if (is_mov) begin
                  s_nxt.gpr[d_idx] = s_r.gpr[r_idx];
               end else if (is_ldi) begin
                  s_nxt.gpr[{1'b1, w[7:4]}] = {w[11:8], w[3:0]};
               end else if (is_mem) begin
                  s_nxt.st         = ST_MEM;
                  s_nxt.dmem.addr  = m_addr;
                  s_nxt.dmem.wdata = s_r.gpr[d_idx];
                  s_nxt.dmem.we    = store;
                  s_nxt.dmem.re    = !store;
                  s_nxt.ld_dst     = d_idx;
                  if (is_abs) begin
                     s_nxt.pc = pc2;
                  end
                  if (inc || dec) begin
                     s_nxt.gpr[m_lo]         = m_new[7:0];
                     s_nxt.gpr[m_lo | 5'h01] = m_new[15:8];
                  end
               end else begin
                  s_nxt.badop = 1'b1;
               end
            end
         end
         ST_MEM: begin
            if (s_r.dmem.re) begin
               s_nxt.gpr[s_r.ld_dst] = dmem_rdata_i;
            end
            s_nxt.st = ST_IDLE;
         end
         ST_FLUSH: begin
            s_nxt.st = ST_IDLE;
         end
         default: begin
            s_nxt.st = ST_IDLE;
         end
      endcase
      s_nxt.ready   = s_nxt.run && (s_nxt.st == ST_IDLE);
      s_nxt.awready = !s_nxt.aw_hold && !s_nxt.bvalid;
      s_nxt.wready  = !s_nxt.w_hold && !s_nxt.bvalid;
      s_nxt.arready = !s_nxt.rvalid;
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_r       <= '0;
         s_r.st    <= ST_IDLE;
         s_r.pc    <= RST_PC;
         s_r.flags <= RST_FLAGS;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign instr_ready_o   = s_r.ready;
   assign pc_o            = s_r.pc;
   assign flush_o         = s_r.flush;
   assign flags_o         = s_r.flags;
   assign dmem_req_o      = s_r.dmem;
   assign s_axi_awready_o = s_r.awready;
   assign s_axi_wready_o  = s_r.wready;
   assign s_axi_bresp_o   = s_r.bresp;
   assign s_axi_bvalid_o  = s_r.bvalid;
   assign s_axi_arready_o = s_r.arready;
   assign s_axi_rdata_o   = s_r.rdata;
   assign s_axi_rresp_o   = s_r.rresp;
   assign s_axi_rvalid_o  = s_r.rvalid;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   br_taken_a: assert property (acc && is_br && br_cond |=>
      s_r.flush && s_r.pc == $past(br_tgt) && !s_r.ready ##1 s_r.st == ST_IDLE)
      else $error("taken branch target or stall wrong");
   br_skip_a: assert property (acc && is_br && !br_cond |=>
      !s_r.flush && s_r.pc == $past(pc1) && s_r.st == ST_IDLE)
      else $error("untaken branch not single cycle");
   br_flags_a: assert property (acc && is_br |=>
      s_r.flags == $past(s_r.flags)) else $error("branch changed flags");
   signed_cond_a: assert property (acc && is_br && w[2:0] == F_S |->
      br_cond == (w[10] ^ s_r.flags[F_N] ^ s_r.flags[F_V]))
      else $error("signed branch condition wrong");
   carry_cond_a: assert property (acc && is_br && w[2:0] == F_C |->
      br_cond == (s_r.flags[F_C] ^ w[10])) else $error("carry branch condition wrong");
   copy_one_a: assert property (acc && is_mov |=>
      s_r.gpr[$past(d_idx)] == $past(s_r.gpr[r_idx]) && s_r.st == ST_IDLE
      && s_r.flags == $past(s_r.flags)) else $error("register copy wrong");
   load_data_a: assert property (s_r.st == ST_MEM && s_r.dmem.re |=>
      s_r.gpr[$past(s_r.ld_dst)] == $past(dmem_rdata_i))
      else $error("load data not written");
   mem_two_a: assert property (acc && is_mem |=>
      s_r.st == ST_MEM && !s_r.ready ##1 s_r.st == ST_IDLE)
      else $error("memory access not two cycles");
   predec_a: assert property (acc && dec |=>
      s_r.dmem.addr == $past(m_ptr) - 16'h0001
      && ptr_get(s_r.gpr, $past(m_lo)) == s_r.dmem.addr)
      else $error("pre-decrement address wrong");
   postinc_a: assert property (acc && inc |=>
      s_r.dmem.addr == $past(m_ptr)
      && ptr_get(s_r.gpr, $past(m_lo)) == $past(m_ptr) + 16'h0001)
      else $error("post-increment wrong");
   disp_a: assert property (acc && is_disp |=>
      s_r.dmem.addr == $past(m_ptr) + {10'h000, $past(w[13]), $past(w[11:10]),
      $past(w[2:0])} && ptr_get(s_r.gpr, $past(m_lo)) == $past(m_ptr))
      else $error("displacement access wrong");
   abs_store_a: assert property (acc && is_abs && store |=>
      s_r.dmem.we && !s_r.dmem.re && s_r.dmem.addr == $past(instr_i.ext)
      && s_r.dmem.wdata == $past(s_r.gpr[d_idx]) && s_r.pc == $past(pc2))
      else $error("absolute store wrong");

   taken_c: cover property (acc && is_br && br_cond ##2 acc);
   untaken_c: cover property (acc && is_br && !br_cond ##1 acc);
   load_inc_c: cover property (acc && inc && !store ##2 acc);
   store_dec_c: cover property (acc && dec && store);
   bus_write_c: cover property (s_r.bvalid && s_axi_bready_i);
endmodule : bdx_exec
`default_nettype wire

// *** verif/test_branch_and_data_transfer_exec.sv ***
`default_nettype none
module test_branch_and_data_transfer_exec;
   import bdx_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic          clk = 1'b0, nrst = 1'b0, iv, awv, wv, bry, arv, rry;
   logic          irdy, fl, awr, wr, bv, arr, rv;
   bdx_instr_s    ins;
   bdx_dmem_req_s dm;
   logic [7:0]    md, flg;
   logic [15:0]   pc, exp_pc;
   logic [11:0]   awa, ara;
   logic [31:0]   wd, rd;
   logic [1:0]    br, rr;
   int            err_count = 0, num_checks = 0, cycles = 0;
   // operation table: loads then stores
   localparam logic [15:0] OPW [8] = '{16'h901d, 16'h902a, 16'h8035, 16'h9040,
                                       16'h930d, 16'h9232, 16'hae1f, 16'h9220};
   localparam logic [15:0] OPE [8] = '{0, 0, 0, 16'h0123, 0, 0, 0, 16'h0200};
   localparam logic [15:0] OPA [8] = '{16'h40, 16'h7f, 16'hc5, 16'h123,
                                       16'h41, 16'hbf, 16'hbe, 16'h200};
   localparam logic [7:0]  OPD [8] = '{0, 0, 0, 0, 8'ha5, 8'hf9, 8'h7c, 8'h43};
   localparam logic [4:0]  RIX [7] = '{1, 2, 3, 4, 26, 28, 30};
   localparam logic [7:0]  RVL [7] = '{8'h7c, 8'h43, 8'hf9, 8'h1f, 8'h42, 8'h7f, 8'hbf};
   always #4 clk = ~clk;
   // memory answers with a pattern of its address
   always_comb md = dm.addr[7:0] ^ 8'h3c;
   bdx_exec dut_u (.sys_clk_i(clk), .nrst_i(nrst), .instr_valid_i(iv), .instr_i(ins),
      .instr_ready_o(irdy), .pc_o(pc), .flush_o(fl), .flags_o(flg), .dmem_req_o(dm),
      .dmem_rdata_i(md), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
      .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wr), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bry), .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv),
      .s_axi_arready_o(arr), .s_axi_rdata_o(rd), .s_axi_rresp_o(rr),
      .s_axi_rvalid_o(rv), .s_axi_rready_i(rry));
   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : complete_run
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count++;
         complete_run();
      end
   end
   task automatic chk(input bit ok, input string msg);
      num_checks++;
      if (!ok) begin
         err_count++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask : chk
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
      logic da, dw, ta, tw, tb;
      @(posedge clk);
      awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
      da = 0; dw = 0; tb = 0;
      while (!tb) begin
         @(negedge clk);
         ta = awr && !da; tw = wr && !dw; tb = bv;
         @(posedge clk);
         if (ta) begin da = 1; awv <= 1'b0; end
         if (tw) begin dw = 1; wv <= 1'b0; end
      end
      bry <= 1'b0;
      chk(br === RESP_OKAY, "write response");
   endtask : axi_wr
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      logic t;
      @(posedge clk);
      ara <= a; arv <= 1'b1; rry <= 1'b1; t = 0;
      while (!t) begin @(negedge clk); t = arr; @(posedge clk); end
      arv <= 1'b0; t = 0;
      while (!t) begin @(negedge clk); t = rv; d = rd; r = rr; @(posedge clk); end
      rry <= 1'b0;
   endtask : axi_rd
   task automatic gpr_wr(input logic [4:0] i, input logic [7:0] v);
      axi_wr(A_GPR_BASE + {5'h0, i, 2'b00}, {24'h0, v});
   endtask : gpr_wr
   task automatic issue(input logic [15:0] w, input logic [15:0] e);
      logic t;
      @(posedge clk);
      iv <= 1'b1; ins <= '{word: w, ext: e}; t = 0;
      while (!t) begin @(negedge clk); t = irdy; @(posedge clk); end
      iv <= 1'b0;
   endtask : issue
   task automatic set_flags(input logic [7:0] f);
      axi_wr(A_CTRL, 32'h0);
      axi_wr(A_FLAGS, {24'h0, f});
      axi_wr(A_CTRL, 32'h1);
      chk(flg === f, "flags write");
   endtask : set_flags
   task automatic test_reset;
      logic [31:0] d;
      logic [1:0]  r;
      chk(pc === 16'h0 && flg === 8'h0 && irdy === 1'b0, "reset outputs");
      axi_rd(12'h040, d, r);
      chk(r === RESP_SLVERR && d === 32'h0, "unmapped read");
      axi_wr(A_PC, 32'h100);
      exp_pc = 16'h100;
   endtask : test_reset
   task automatic run_branches(input logic [7:0] f);
      logic tk;
      logic [6:0] k;
      int s, c;
      set_flags(f);
      for (c = 0; c < 2; c++) begin
         for (s = 0; s < 8; s++) begin
            k = s[0] ? 7'h7c : 7'h06;
            tk = ((s == 4) ? (f[2] ^ f[3]) : f[s]) ^ c[0];
            issue({5'b11110, c[0], k, s[2:0]}, 16'h0);
            exp_pc = exp_pc + (tk ? {{9{k[6]}}, k} + 16'h1 : 16'h1);
            @(negedge clk);
            chk(fl === tk && irdy === !tk && pc === exp_pc, "branch");
            if (tk) begin
               @(negedge clk);
               chk(irdy === 1'b1 && fl === 1'b0, "branch length");
            end
            chk(flg === f, "branch flags");
         end
      end
   endtask : run_branches
   task automatic xfer_regs;
      logic [31:0] d;
      logic [1:0]  r;
      issue(16'hea05, 16'h0);
      exp_pc = exp_pc + 16'h1;
      @(negedge clk);
      chk(irdy === 1'b1 && pc === exp_pc, "immediate cycles");
      issue(16'h2e30, 16'h0);
      exp_pc = exp_pc + 16'h1;
      @(negedge clk);
      chk(irdy === 1'b1 && pc === exp_pc && flg === 8'he3, "copy cycles");
      axi_rd(A_GPR_BASE + 12'h00c, d, r);
      chk(d[7:0] === 8'ha5, "copy data");
      axi_rd(A_GPR_BASE + 12'h044, d, r);
      chk(d[7:0] === 8'h00, "other register kept");
   endtask : xfer_regs
   task automatic mem_ops;
      logic [31:0] d;
      logic [1:0]  r;
      int i;
      axi_wr(A_CTRL, 32'h0);
      for (i = 0; i < 6; i++) gpr_wr(5'(26 + i), i[0] ? 8'h0 : 8'(8'h40 * (i / 2 + 1)));
      axi_wr(A_CTRL, 32'h1);
      for (i = 0; i < 8; i++) begin
         issue(OPW[i], OPE[i]);
         exp_pc = exp_pc + ((OPE[i] != 16'h0) ? 16'h2 : 16'h1);
         @(negedge clk);
         chk(dm.re === (i < 4) && dm.we === (i >= 4) && dm.addr === OPA[i], "access");
         if (i >= 4) chk(dm.wdata === OPD[i] && irdy === 1'b0, "store data");
         @(negedge clk);
         chk(dm.re === 1'b0 && dm.we === 1'b0 && irdy === 1'b1 && pc === exp_pc, "length");
      end
      for (i = 0; i < 7; i++) begin
         axi_rd(A_GPR_BASE + {5'h0, RIX[i], 2'b00}, d, r);
         chk(d[7:0] === RVL[i], "load or pointer result");
      end
      chk(flg === 8'he3, "transfer flags");
   endtask : mem_ops
   task automatic bad_op;
      logic [31:0] d;
      logic [1:0]  r;
      issue(16'hffff, 16'h0);
      exp_pc = exp_pc + 16'h1;
      @(negedge clk);
      chk(pc === exp_pc, "undecoded advance");
      axi_rd(A_STATUS, d, r);
      chk(d[STS_BADOP] === 1'b1, "undecoded status");
   endtask : bad_op
   initial begin
      iv = 0; ins = '0; awv = 0; wv = 0; bry = 0; arv = 0; rry = 0;
      awa = '0; ara = '0; wd = '0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      @(negedge clk);
      test_reset();
      run_branches(8'h1c);
      run_branches(8'he3);
      xfer_regs();
      mem_ops();
      bad_op();
      complete_run();
   end
endmodule : test_branch_and_data_transfer_exec
`default_nettype wire
